// [rtl/txc_apb_regs.sv]
`default_nettype none
module txc_apb_regs
  import txc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_DW-1:0] pwdata,
  output logic [APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [IRQ_W-1:0] irqSet,
  input wire logic [APB_DW-1:0] engineState,
  output logic [ADDR_W-1:0] statusBlockAddr,
  output logic irq
);
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] irqMask;
  logic setup;
  logic access;
  logic mapped;
  logic [IRQ_W-1:0] clrStatus;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign mapped = (paddr == REG_SB_ADDR) || (paddr == REG_IRQ_STATUS) || (paddr == REG_IRQ_MASK) ||
    (paddr == REG_ENGINE);
  assign pslverr = access && !mapped;
  assign clrStatus = (access && !pwrite && paddr == REG_IRQ_STATUS) ? {IRQ_W{1'b1}} : '0;
  assign irq = |(irqStatus & irqMask);

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      statusBlockAddr <= SB_ADDR_RESET;
      irqMask <= IRQ_MASK_RESET;
    end
    else if (access && pwrite)
    begin
      if (paddr == REG_SB_ADDR)
      begin
        statusBlockAddr <= pwdata;
      end
      else if (paddr == REG_IRQ_MASK)
      begin
        irqMask <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // a new event wins over the read that clears
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      irqStatus <= '0;
    end
    else
    begin
      irqStatus <= (irqStatus & ~clrStatus) | irqSet;
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      prdata <= '0;
    end
    else if (setup && !pwrite)
    begin
      if (paddr == REG_SB_ADDR)
      begin
        prdata <= statusBlockAddr;
      end
      else if (paddr == REG_IRQ_STATUS)
      begin
        prdata <= {{(APB_DW-IRQ_W){1'b0}}, irqStatus};
      end
      else if (paddr == REG_IRQ_MASK)
      begin
        prdata <= {{(APB_DW-IRQ_W){1'b0}}, irqMask};
      end
      else if (paddr == REG_ENGINE)
      begin
        prdata <= engineState;
      end
      else
      begin
        prdata <= '0;
      end
    end
  end
endmodule : txc_apb_regs
`default_nettype wire

// [rtl/txc_mem_writer.sv]
`default_nettype none
module txc_mem_writer
  import txc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  txc_wr_if.writer cmd,
  output logic memReq,
  output logic [ADDR_W-1:0] memAddr,
  output logic [WORD_W-1:0] memData,
  input wire logic memAck
);
  logic doneReg;

  // one word in flight; request held until the memory acknowledges
  assign cmd.ready = !memReq && !doneReg;
  assign cmd.done = doneReg;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      memReq <= 1'b0;
      memAddr <= '0;
      memData <= '0;
    end
    else if (cmd.valid && cmd.ready)
    begin
      memReq <= 1'b1;
      memAddr <= cmd.addr;
      memData <= cmd.data;
    end
    else if (memReq && memAck)
    begin
      memReq <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      doneReg <= 1'b0;
    end
    else
    begin
      doneReg <= memReq && memAck;
    end
  end
endmodule : txc_mem_writer
`default_nettype wire

// [rtl/txc_pkg.sv]
`default_nettype none
package txc_pkg;
  localparam int ADDR_W = 32;
  localparam int WORD_W = 16;
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam int FS_W = 8;
  localparam int ERR_W = 6;
  localparam int IRQ_W = 4;
  localparam int CNT_W = 16;

  // control word layout
  localparam int CW_VALID_BIT = 0;
  localparam int CW_DONE_BIT = 1;
  localparam int CW_START_BIT = 2;
  localparam int CW_END_BIT = 3;
  localparam int CW_FINT_BIT = 4;
  localparam int CW_ERR_BIT = 5;
  localparam int CW_RSV_LO = 6;
  localparam int CW_RSV_HI = 7;
  localparam int CW_FS_LO = 8;
  localparam int CW_FS_HI = 15;

  // completion word layout
  localparam int CMP_CMD_BIT = 0;
  localparam int CMP_FRAME_BIT = 1;
  localparam int CMP_LIST_ERR_BIT = 2;
  localparam int CMP_ERR_LO = 8;

  localparam logic [WORD_W-1:0] SB_CMD_CODE = 16'h0004;
  localparam logic [ADDR_W-1:0] SB_OFS_CMD = 32'h00000000;
  localparam logic [ADDR_W-1:0] SB_OFS_CODE = 32'h00000002;
  localparam logic [ADDR_W-1:0] SB_OFS_HIGH = 32'h00000004;
  localparam logic [ADDR_W-1:0] SB_OFS_LOW = 32'h00000006;
  localparam logic [ADDR_W-1:0] LIST_CTRL_OFS = 32'h00000002;

  localparam logic [APB_AW-1:0] REG_SB_ADDR = 12'h000;
  localparam logic [APB_AW-1:0] REG_IRQ_STATUS = 12'h004;
  localparam logic [APB_AW-1:0] REG_IRQ_MASK = 12'h008;
  localparam logic [APB_AW-1:0] REG_ENGINE = 12'h00c;

  localparam logic [ADDR_W-1:0] SB_ADDR_RESET = 32'h00000000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

  typedef enum logic [1:0]
  {
    EVT_CHAIN = 2'b00,
    EVT_HALT = 2'b01,
    EVT_FRAME = 2'b10,
    EVT_LIST_ERR = 2'b11
  } txc_evt_e;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_WR_CTRL = 3'b001,
    ST_WR_CMD = 3'b010,
    ST_WR_CODE = 3'b011,
    ST_WR_HIGH = 3'b100,
    ST_WR_LOW = 3'b101,
    ST_POST = 3'b110
  } txc_state_e;
endpackage : txc_pkg
`default_nettype wire

// [rtl/txc_wr_if.sv]
`default_nettype none
interface txc_wr_if;
  import txc_pkg::*;
  logic valid;
  logic ready;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] data;
  logic done;
  modport issuer (output valid, output addr, output data, input ready, input done);
  modport writer (input valid, input addr, input data, output ready, output done);
endinterface : txc_wr_if
`default_nettype wire

// [rtl/txc_writeback.sv]
// Function
// - written control word clears ownership bit 0
// - written control word sets done bit 1
// - bits 2-4 copied from request word
// - reserved bits 6-7 copied from request
// - bit 5 flags send or strip failure
// - bits 8-15 carry returned frame status byte
// - interrupt when whole chain has been sent
// - interrupt when stop command has finished
// - interrupt after frame-start list with interrupt flag
// - interrupt on list parameter error
// - status block: code, completion, address high, low
// - only frame-start control word is rewritten
`default_nettype none
module txc_writeback
  import txc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_DW-1:0] pwdata,
  output logic [APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic evtValid,
  output logic evtReady,
  input wire logic [1:0] evtKind,
  input wire logic [ADDR_W-1:0] evtListAddr,
  input wire logic [WORD_W-1:0] list_request_word,
  input wire logic evtTxError,
  input wire logic [FS_W-1:0] returned_frame_status_byte,
  input wire logic [ERR_W-1:0] evtListErrBits,
  output logic memReq,
  output logic [ADDR_W-1:0] memAddr,
  output logic [WORD_W-1:0] memData,
  input wire logic memAck,
  output logic irq
);
  txc_wr_if wr ();

  txc_state_e state;
  txc_state_e next_state;
  txc_evt_e kind;
  logic [ADDR_W-1:0] listAddr;
  logic [WORD_W-1:0] reqWord;
  logic txError;
  logic [FS_W-1:0] stripped_status_copy;
  logic [ERR_W-1:0] errBits;
  logic pending;
  logic [CNT_W-1:0] wbCount;
  logic [CNT_W-1:0] postCount;
  logic [ADDR_W-1:0] statusBlockAddr;
  logic [IRQ_W-1:0] irqSet;
  logic [WORD_W-1:0] list_control_word;
  logic [WORD_W-1:0] send_completion_word;
  logic isWriteState;
  logic stepDone;
  logic frameStart;
  logic frameIrq;
  logic [APB_DW-1:0] engineState;

  assign frameStart = reqWord[CW_START_BIT];
  assign frameIrq = reqWord[CW_FINT_BIT] && frameStart;

  // control word rewritten into the frame-start list
  always_comb
  begin
    list_control_word = '0;
    list_control_word[CW_VALID_BIT] = 1'b0;
    list_control_word[CW_DONE_BIT] = 1'b1;
    list_control_word[CW_START_BIT] = reqWord[CW_START_BIT];
    list_control_word[CW_END_BIT] = reqWord[CW_END_BIT];
    list_control_word[CW_FINT_BIT] = reqWord[CW_FINT_BIT];
    list_control_word[CW_ERR_BIT] = txError;
    list_control_word[CW_RSV_HI:CW_RSV_LO] = reqWord[CW_RSV_HI:CW_RSV_LO];
    list_control_word[CW_FS_HI:CW_FS_LO] = stripped_status_copy;
  end

  // completion word posted in the status block
  always_comb
  begin
    send_completion_word = '0;
    case (kind)
      EVT_CHAIN:
      begin
        send_completion_word[CMP_CMD_BIT] = 1'b1;
      end
      EVT_HALT:
      begin
        send_completion_word[CMP_CMD_BIT] = 1'b1;
      end
      EVT_FRAME:
      begin
        send_completion_word[CMP_FRAME_BIT] = 1'b1;
      end
      EVT_LIST_ERR:
      begin
        send_completion_word[CMP_LIST_ERR_BIT] = 1'b1;
        send_completion_word[CMP_ERR_LO +: ERR_W] = errBits;
      end
      default:
      begin
        send_completion_word = '0;
      end
    endcase
  end

  assign evtReady = (state == ST_IDLE);
  assign isWriteState = (state == ST_WR_CTRL) || (state == ST_WR_CMD) || (state == ST_WR_CODE) ||
    (state == ST_WR_HIGH) || (state == ST_WR_LOW);
  assign stepDone = pending && wr.done;
  assign wr.valid = isWriteState && !pending;

  // address and data of the word written in each state
  always_comb
  begin
    wr.addr = '0;
    wr.data = '0;
    case (state)
      ST_WR_CTRL:
      begin
        wr.addr = listAddr + LIST_CTRL_OFS;
        wr.data = list_control_word;
      end
      ST_WR_CMD:
      begin
        wr.addr = statusBlockAddr + SB_OFS_CMD;
        wr.data = SB_CMD_CODE;
      end
      ST_WR_CODE:
      begin
        wr.addr = statusBlockAddr + SB_OFS_CODE;
        wr.data = send_completion_word;
      end
      ST_WR_HIGH:
      begin
        wr.addr = statusBlockAddr + SB_OFS_HIGH;
        wr.data = listAddr[ADDR_W-1:WORD_W];
      end
      ST_WR_LOW:
      begin
        wr.addr = statusBlockAddr + SB_OFS_LOW;
        wr.data = listAddr[WORD_W-1:0];
      end
      default:
      begin
        wr.addr = '0;
        wr.data = '0;
      end
    endcase
  end

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (evtValid)
        begin
          if (txc_evt_e'(evtKind) == EVT_FRAME)
          begin
            if (list_request_word[CW_START_BIT])
            begin
              next_state = ST_WR_CTRL;
            end
            else if (list_request_word[CW_FINT_BIT])
            begin
              next_state = ST_IDLE;
            end
          end
          else
          begin
            next_state = ST_WR_CMD;
          end
        end
      end
      ST_WR_CTRL:
      begin
        if (stepDone)
        begin
          // status block only after the control word has landed
          next_state = frameIrq ? ST_WR_CMD : ST_IDLE;
        end
      end
      ST_WR_CMD:
      begin
        if (stepDone)
        begin
          next_state = ST_WR_CODE;
        end
      end
      ST_WR_CODE:
      begin
        if (stepDone)
        begin
          next_state = ST_WR_HIGH;
        end
      end
      ST_WR_HIGH:
      begin
        if (stepDone)
        begin
          next_state = ST_WR_LOW;
        end
      end
      ST_WR_LOW:
      begin
        if (stepDone)
        begin
          next_state = ST_POST;
        end
      end
      ST_POST:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // event fields held for the whole sequence
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      kind <= EVT_CHAIN;
      listAddr <= '0;
      reqWord <= '0;
      txError <= 1'b0;
      stripped_status_copy <= '0;
      errBits <= '0;
    end
    else if (evtValid && evtReady)
    begin
      kind <= txc_evt_e'(evtKind);
      listAddr <= evtListAddr;
      reqWord <= list_request_word;
      txError <= evtTxError;
      stripped_status_copy <= returned_frame_status_byte;
      errBits <= evtListErrBits;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      pending <= 1'b0;
    end
    else if (wr.valid && wr.ready)
    begin
      pending <= 1'b1;
    end
    else if (wr.done)
    begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      wbCount <= '0;
    end
    else if (state == ST_WR_CTRL && stepDone)
    begin
      wbCount <= wbCount + 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      postCount <= '0;
    end
    else if (state == ST_POST)
    begin
      postCount <= postCount + 1'b1;
    end
  end

  // interrupt raised once the status block is complete
  always_comb
  begin
    irqSet = '0;
    if (state == ST_POST)
    begin
      case (kind)
        EVT_CHAIN:
        begin
          irqSet[EVT_CHAIN] = 1'b1;
        end
        EVT_HALT:
        begin
          irqSet[EVT_HALT] = 1'b1;
        end
        EVT_FRAME:
        begin
          irqSet[EVT_FRAME] = 1'b1;
        end
        EVT_LIST_ERR:
        begin
          irqSet[EVT_LIST_ERR] = 1'b1;
        end
        default:
        begin
          irqSet = '0;
        end
      endcase
    end
  end

  assign engineState = {postCount[CNT_W/2-1:0], wbCount[CNT_W/2-1:0], {(CNT_W-3){1'b0}}, state};

  txc_mem_writer u_writer
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .cmd(wr),
    .memReq(memReq),
    .memAddr(memAddr),
    .memData(memData),
    .memAck(memAck)
  );

  txc_apb_regs u_regs
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irqSet(irqSet),
    .engineState(engineState),
    .statusBlockAddr(statusBlockAddr),
    .irq(irq)
  );
endmodule : txc_writeback
`default_nettype wire

// [tb/txc_host_mem.sv]
`default_nettype none
module txc_host_mem
  import txc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [1:0] delay,
  input wire logic memReq,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic [WORD_W-1:0] memData,
  output logic memAck
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ADDR_W+WORD_W-1:0] wq[$];
  logic [FS_W-1:0] lastFs;
  logic [1:0] cnt;
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      memAck <= 1'b0;
      cnt <= 2'h0;
    end
    else if (memReq && memAck)
    begin
      wq.push_back({memAddr, memData});
      if (!memData[CW_ERR_BIT])
        lastFs <= memData[CW_FS_HI:CW_FS_LO];
      memAck <= 1'b0;
    end
    else if (memReq)
    begin
      if (cnt >= delay)
      begin
        memAck <= 1'b1;
        cnt <= 2'h0;
      end
      else
        cnt <= cnt + 2'h1;
    end
  end
endmodule : txc_host_mem
`default_nettype wire

// [tb/txc_writeback_checker.sv]
`default_nettype none
module txc_writeback_checker
  import txc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic evtValid,
  input wire logic evtReady,
  input wire logic [1:0] evtKind,
  input wire logic [ADDR_W-1:0] evtListAddr,
  input wire logic [WORD_W-1:0] list_request_word,
  input wire logic evtTxError,
  input wire logic [FS_W-1:0] returned_frame_status_byte,
  input wire logic memReq,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic [WORD_W-1:0] memData,
  input wire logic memAck
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  sequence s_ctrl;
    memReq && evtKind == EVT_FRAME && memAddr == evtListAddr + LIST_CTRL_OFS;
  endsequence
  sequence s_take;
    evtValid && evtReady && evtKind == EVT_FRAME;
  endsequence
  property p_valid_clr;
    s_ctrl |-> !memData[CW_VALID_BIT];
  endproperty
  a_valid_clr: assert property (p_valid_clr) else $error("ownership bit left set");
  property p_done_set;
    s_ctrl |-> memData[CW_DONE_BIT];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done bit not set");
  property p_flags;
    s_ctrl |-> memData[CW_FINT_BIT:CW_START_BIT] == list_request_word[CW_FINT_BIT:CW_START_BIT];
  endproperty
  a_flags: assert property (p_flags) else $error("frame flags not copied");
  property p_rsv;
    s_ctrl |-> memData[CW_RSV_HI:CW_RSV_LO] == list_request_word[CW_RSV_HI:CW_RSV_LO];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits changed");
  property p_err;
    s_ctrl |-> memData[CW_ERR_BIT] == evtTxError;
  endproperty
  a_err: assert property (p_err) else $error("failure bit wrong");
  property p_fs;
    s_ctrl |-> memData[CW_FS_HI:CW_FS_LO] == returned_frame_status_byte;
  endproperty
  a_fs: assert property (p_fs) else $error("status byte not copied");
  property p_refuse;
    s_take and !list_request_word[CW_START_BIT] |=> !memReq [*2];
  endproperty
  a_refuse: assert property (p_refuse) else $error("write for list without frame start");
  property p_ctrl_first;
    s_take and list_request_word[CW_START_BIT] |=> ##1 s_ctrl;
  endproperty
  a_ctrl_first: assert property (p_ctrl_first) else $error("control word not written first");
  property p_hold;
    memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memData);
  endproperty
  a_hold: assert property (p_hold) else $error("memory request dropped or changed");
  property p_idle;
    evtReady |-> !memReq;
  endproperty
  a_idle: assert property (p_idle) else $error("memory write while idle");
endmodule : txc_writeback_checker
bind txc_writeback txc_writeback_checker u_chk (.core_clk(core_clk), .nrst(nrst), .evtValid(evtValid),
  .evtReady(evtReady), .evtKind(evtKind), .evtListAddr(evtListAddr), .list_request_word(list_request_word),
  .evtTxError(evtTxError), .returned_frame_status_byte(returned_frame_status_byte), .memReq(memReq),
  .memAddr(memAddr), .memData(memData), .memAck(memAck));
`default_nettype wire

// [tb/txc_writeback_test.sv]
`default_nettype none
module txc_writeback_test;
  import txc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SBA = 32'h00001000;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, evtReady, memReq, memAck, irq;
  logic evtValid = 1'b0;
  logic [1:0] evtKind = 2'h0;
  logic [31:0] evtListAddr = 32'h0;
  logic [15:0] list_request_word = 16'h0;
  logic evtTxError = 1'b0;
  logic [7:0] returned_frame_status_byte = 8'h0;
  logic [5:0] evtListErrBits = 6'h0;
  logic [31:0] memAddr;
  logic [15:0] memData;
  logic [1:0] dly = 2'h0;
  logic [15:0] lfsr = 16'h0024;
  logic [47:0] exp[$];
  int fails = 0;
  int num_checks = 0;
  int nWb = 0;
  int nPost = 0;
  int cyc = 0;
  always #2.5 core_clk = ~core_clk;
  txc_writeback u_dut (.core_clk(core_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evtValid(evtValid),
    .evtReady(evtReady), .evtKind(evtKind), .evtListAddr(evtListAddr), .list_request_word(list_request_word),
    .evtTxError(evtTxError), .returned_frame_status_byte(returned_frame_status_byte),
    .evtListErrBits(evtListErrBits), .memReq(memReq), .memAddr(memAddr), .memData(memData), .memAck(memAck),
    .irq(irq));
  txc_host_mem u_mem (.core_clk(core_clk), .nrst(nrst), .delay(dly), .memReq(memReq), .memAddr(memAddr),
    .memData(memData), .memAck(memAck));
  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] want);
    num_checks++;
    if (seen !== want)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next request never re-raises psel in this time step
    @(posedge core_clk);
  endtask : apb
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  task automatic rdchk(input logic [11:0] a, input logic [31:0] want, input logic wantErr);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk("read data", {16'h0, rd}, {16'h0, want});
    chk("slave error", {47'h0, e}, {47'h0, wantErr});
  endtask : rdchk
  // expected memory writes; returns the status bit the event should set
  function automatic logic [3:0] model(input logic [1:0] k, input logic [31:0] la, input logic [15:0] rq,
    input logic te, input logic [7:0] fs, input logic [5:0] eb);
    logic [15:0] cmp;
    if (k == EVT_FRAME)
    begin
      if (!rq[CW_START_BIT])
        return 4'h0;
      exp.push_back({la + LIST_CTRL_OFS, fs, rq[7:6], te, rq[4:2], 2'b10});
      nWb++;
      if (!rq[CW_FINT_BIT])
        return 4'h0;
      cmp = 16'h0002;
    end
    else
      cmp = (k == EVT_LIST_ERR) ? {2'b00, eb, 8'h04} : 16'h0001;
    nPost++;
    exp.push_back({SBA + SB_OFS_CMD, SB_CMD_CODE});
    exp.push_back({SBA + SB_OFS_CODE, cmp});
    exp.push_back({SBA + SB_OFS_HIGH, la[31:16]});
    exp.push_back({SBA + SB_OFS_LOW, la[15:0]});
    return 4'h1 << k;
  endfunction : model
  task automatic evt(input logic [1:0] k, input logic [15:0] rq, output logic [3:0] st);
    int t;
    lfsr = lfsr_next(lfsr);
    st = model(k, {14'h0008, lfsr, 2'b00}, rq, lfsr[3], lfsr[11:4], lfsr[15:10]);
    dly <= lfsr[1:0];
    evtKind <= k;
    evtListAddr <= {14'h0008, lfsr, 2'b00};
    list_request_word <= rq;
    evtTxError <= lfsr[3];
    returned_frame_status_byte <= lfsr[11:4];
    evtListErrBits <= lfsr[15:10];
    evtValid <= 1'b1;
    #1;
    while (evtReady !== 1'b1) @(posedge core_clk) #1;
    @(posedge core_clk);
    evtValid <= 1'b0;
    t = 0;
    #1;
    while (evtReady !== 1'b1 && t < 300)
    begin
      @(posedge core_clk) #1;
      t++;
    end
    repeat (2) @(posedge core_clk);
    chk("write count", 48'(u_mem.wq.size()), 48'(exp.size()));
    while (exp.size() > 0 && u_mem.wq.size() > 0)
      chk("memory write", u_mem.wq.pop_front(), exp.pop_front());
    exp.delete();
    u_mem.wq.delete();
  endtask : evt
  initial
  begin
    logic [3:0] st;
    logic [31:0] rd;
    logic e;
    logic [15:0] rq;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rdchk(REG_SB_ADDR, SB_ADDR_RESET, 1'b0);
    rdchk(REG_IRQ_MASK, {28'h0, IRQ_MASK_RESET}, 1'b0);
    rdchk(REG_IRQ_STATUS, 32'h0, 1'b0);
    rdchk(12'h010, 32'h0, 1'b1);
    apb(1'b1, REG_SB_ADDR, SBA, rd, e);
    apb(1'b1, REG_IRQ_MASK, 32'h0000000f, rd, e);
    rdchk(REG_IRQ_MASK, 32'h0000000f, 1'b0);
    $display("registers test done");
    for (int i = 0; i < 24; i++)
    begin
      rq = lfsr ^ 16'(i * 16'h3b5);
      rq[CW_START_BIT] = (i % 7 != 6);
      evt(2'(i), rq, st);
      chk("irq raised", {47'h0, irq}, {47'h0, |st});
      rdchk(REG_IRQ_STATUS, {28'h0, st}, 1'b0);
      chk("irq cleared", {47'h0, irq}, 48'h0);
    end
    $display("events test done");
    apb(1'b1, REG_IRQ_MASK, 32'h0, rd, e);
    evt(EVT_CHAIN, 16'h0, st);
    chk("irq masked", {47'h0, irq}, 48'h0);
    rdchk(REG_IRQ_STATUS, 32'h00000001, 1'b0);
    // engine register: posted blocks, written-back frames, idle state
    rdchk(REG_ENGINE, {8'(nPost), 8'(nWb), 16'h0}, 1'b0);
    $display("mask test done");
    tally_and_finish();
  end
endmodule : txc_writeback_test
`default_nettype wire
